//--- include/orx_consts.svh
// constants for the overlay region transaction block
// assumes an upstream bus front-end that decodes bus cycles into one-cycle commands
`ifndef ORX_CONSTS_SVH
`define ORX_CONSTS_SVH
`define ORX_CRC_POLY  32'h04c11db7
`define ORX_CRC_INIT  32'hffffffff
`define ORX_BOOT_RST  32'h00000000
`define ORX_LCRC_CLR  32'h00000000
`define ORX_HP_LSB    3
`define ORX_HI_BIT    0
`endif

//--- include/orx_pkg.sv
// types for the overlay region transaction block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package orx_pkg;
  // decoded host transactions
  typedef enum logic [4:0] {
    op_read_array, op_ecc_overlay_entry, op_read_ecc_status,
    op_read_trap_low, op_read_trap_high, op_read_correction_count,
    op_clear_ecc_flags, op_overlay_exit, op_link_crc_overlay_entry,
    op_read_link_crc, op_array_crc_overlay_entry, op_load_crc_start,
    op_load_crc_end, op_pause_array_crc, op_read_array_while_paused,
    op_continue_array_crc, op_read_array_crc_low, op_read_array_crc_high,
    op_boot_cfg_overlay_entry, op_program_boot_cfg, op_read_boot_cfg
  } orx_op_t;
  // active overlay
  typedef enum logic [2:0] {ovl_none, ovl_ecc, ovl_link, ovl_acrc, ovl_boot} orx_ovl_t;
  // read data source
  typedef enum logic [3:0] {
    src_zero, src_arr, src_eccst, src_trapl, src_traph, src_cnt,
    src_lcrc, src_acrc, src_boot
  } orx_src_t;
  typedef struct packed {
    logic        vld;
    orx_op_t     op;
    logic [31:0] addr;
    logic [15:0] wdata;
  } orx_cmd_t;
  typedef struct packed {
    logic        vld;
    logic [15:0] data;
  } orx_rsp_t;
  typedef struct packed {
    logic     vld;
    orx_src_t src;
    logic     hi;
  } orx_pend_t;
endpackage
`default_nettype wire

//--- core/orx_core.sv
// overlay region command interpreter
// assumes decoded one-cycle commands and an array with one cycle read latency
`timescale 1ns/10ps
`default_nettype none
`include "orx_consts.svh"

module orx_core #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // host commands and replies
  input  wire orx_pkg::orx_cmd_t cmd,
  output orx_pkg::orx_rsp_t      rsp_q,
  // memory array port, data one cycle after request
  output logic                   arr_req_q,
  output logic [31:0]            arr_addr_q,
  input  wire logic [15:0]       arr_rdata,
  input  wire logic [15:0]       ecc_hp_status,
  // correction events from the array
  input  wire logic              ecc_evt,
  input  wire logic [31:0]       ecc_evt_addr,
  input  wire logic              ecc_evt_fail,
  output logic                   ecc_irq_q,
  // link crc updates from the bus front-end
  input  wire logic              lcrc_upd,
  input  wire logic [31:0]       lcrc_val,
  // state seen outside
  output orx_pkg::orx_ovl_t      ovl_q,
  output logic                   acrc_busy_q
);

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  orx_pkg::orx_ovl_t  ovl_d;
  orx_pkg::orx_rsp_t  rsp_d;
  orx_pkg::orx_pend_t p1_q, p1_d, p2_q;
  logic [31:0]        trap_q, trap_d, lcrc_q, lcrc_d, boot_q, boot_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic               fail_d, arr_req_d, busy_d;
  logic [31:0]        arr_addr_d;
  logic [31:0]        st_q, st_d, en_q, en_d, cur_q, cur_d;
  logic [31:0]        acrc_q, acrc_d;
  logic               pause_q, pause_d;
  logic [1:0]         ep_q, ep_d;
  logic               in_ecc, in_link, in_acrc, in_boot;
  logic               host_arr, issue;
  logic [31:0]        host_addr;

  // fold one array word into the check value
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [15:0] w);
    logic [31:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[31] ^ w[i]) ? ((r << 1) ^ `ORX_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign in_ecc  = (ovl_q == orx_pkg::ovl_ecc);
  assign in_link = (ovl_q == orx_pkg::ovl_link);
  assign in_acrc = (ovl_q == orx_pkg::ovl_acrc);
  assign in_boot = (ovl_q == orx_pkg::ovl_boot);

  //------------------------------------------------------------
  // command decode and overlay registers
  //------------------------------------------------------------
  // next values of overlay, registers and read pipeline
  always_comb begin
    ovl_d     = ovl_q;
    trap_d    = trap_q;
    cnt_d     = cnt_q;
    fail_d    = ecc_irq_q;
    lcrc_d    = lcrc_upd ? lcrc_val : lcrc_q;
    boot_d    = boot_q;
    st_d      = st_q;
    en_d      = en_q;
    pause_d   = pause_q;
    p1_d      = '0;
    host_arr  = 1'b0;
    host_addr = cmd.addr;
    if (cmd.vld) begin
      p1_d.hi = cmd.addr[`ORX_HI_BIT];
      case (cmd.op)
        orx_pkg::op_ecc_overlay_entry: ovl_d = orx_pkg::ovl_ecc;
        orx_pkg::op_link_crc_overlay_entry: ovl_d = orx_pkg::ovl_link;
        orx_pkg::op_array_crc_overlay_entry: ovl_d = orx_pkg::ovl_acrc;
        orx_pkg::op_boot_cfg_overlay_entry: ovl_d = orx_pkg::ovl_boot;
        orx_pkg::op_overlay_exit: ovl_d = orx_pkg::ovl_none;
        orx_pkg::op_read_array: begin
          p1_d.vld = 1'b1;
          if (ovl_q == orx_pkg::ovl_none || (in_acrc && pause_q)) begin
            p1_d.src = orx_pkg::src_arr;
            host_arr = 1'b1;
          end else if (in_acrc) begin
            p1_d.src = orx_pkg::src_acrc;
          end else begin
            p1_d.src = orx_pkg::src_zero;
          end
        end
        orx_pkg::op_read_ecc_status: begin
          p1_d.vld = 1'b1;
          if (in_ecc) begin
            p1_d.src  = orx_pkg::src_eccst;
            host_arr  = 1'b1;
            host_addr = {cmd.addr[31:`ORX_HP_LSB], {`ORX_HP_LSB{1'b0}}};
          end
        end
        orx_pkg::op_read_trap_low: begin
          p1_d.vld = 1'b1;
          if (in_ecc) p1_d.src = orx_pkg::src_trapl;
        end
        orx_pkg::op_read_trap_high: begin
          p1_d.vld = 1'b1;
          if (in_ecc) p1_d.src = orx_pkg::src_traph;
        end
        orx_pkg::op_read_correction_count: begin
          p1_d.vld = 1'b1;
          if (in_ecc) p1_d.src = orx_pkg::src_cnt;
        end
        orx_pkg::op_clear_ecc_flags: begin
          if (in_ecc) begin
            fail_d = 1'b0;
            cnt_d  = '0;
          end
        end
        orx_pkg::op_read_link_crc: begin
          p1_d.vld = 1'b1;
          if (in_link) p1_d.src = orx_pkg::src_lcrc;
        end
        orx_pkg::op_load_crc_start: if (in_acrc) st_d = cmd.addr;
        orx_pkg::op_load_crc_end: if (in_acrc) en_d = cmd.addr;
        orx_pkg::op_pause_array_crc: if (in_acrc && acrc_busy_q) pause_d = 1'b1;
        orx_pkg::op_continue_array_crc: if (in_acrc) pause_d = 1'b0;
        orx_pkg::op_read_array_while_paused: begin
          p1_d.vld = 1'b1;
          if (in_acrc && pause_q) begin
            p1_d.src = orx_pkg::src_arr;
            host_arr = 1'b1;
          end
        end
        orx_pkg::op_read_array_crc_low, orx_pkg::op_read_array_crc_high: begin
          p1_d.vld = 1'b1;
          p1_d.hi  = (cmd.op == orx_pkg::op_read_array_crc_high);
          if (in_acrc) p1_d.src = orx_pkg::src_acrc;
        end
        orx_pkg::op_program_boot_cfg: begin
          if (in_boot && cmd.addr[`ORX_HI_BIT]) boot_d[31:16] = cmd.wdata;
          else if (in_boot) boot_d[15:0] = cmd.wdata;
        end
        orx_pkg::op_read_boot_cfg: begin
          p1_d.vld = 1'b1;
          if (in_boot) p1_d.src = orx_pkg::src_boot;
        end
        default: p1_d = '0;
      endcase
    end
    // leaving the link overlay wipes its register
    if (in_link && ovl_d != orx_pkg::ovl_link) lcrc_d = `ORX_LCRC_CLR;
    // a new event wins over a clear in the same cycle
    if (ecc_evt) begin
      trap_d = ecc_evt_addr;
      cnt_d  = (cnt_d == '1) ? cnt_d : cnt_d + 1'b1;
      if (ecc_evt_fail) fail_d = 1'b1;
    end
    // reply stage picks its source
    rsp_d.vld = p2_q.vld;
    case (p2_q.src)
      orx_pkg::src_arr:   rsp_d.data = arr_rdata;
      orx_pkg::src_eccst: rsp_d.data = ecc_hp_status;
      orx_pkg::src_trapl: rsp_d.data = trap_q[15:0];
      orx_pkg::src_traph: rsp_d.data = trap_q[31:16];
      orx_pkg::src_cnt:   rsp_d.data = 16'(cnt_q);
      orx_pkg::src_lcrc:  rsp_d.data = p2_q.hi ? lcrc_q[31:16] : lcrc_q[15:0];
      orx_pkg::src_acrc:  rsp_d.data = p2_q.hi ? acrc_q[31:16] : acrc_q[15:0];
      orx_pkg::src_boot:  rsp_d.data = p2_q.hi ? boot_q[31:16] : boot_q[15:0];
      default:            rsp_d.data = 16'h0000;
    endcase
  end

  // register overlay state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovl_q     <= orx_pkg::ovl_none;
      trap_q    <= '0;
      cnt_q     <= '0;
      ecc_irq_q <= 1'b0;
      lcrc_q    <= `ORX_LCRC_CLR;
      boot_q    <= `ORX_BOOT_RST;
      st_q      <= '0;
      en_q      <= '0;
      pause_q   <= 1'b0;
      p1_q      <= '0;
      p2_q      <= '0;
      rsp_q     <= '0;
    end else begin
      ovl_q     <= ovl_d;
      trap_q    <= trap_d;
      cnt_q     <= cnt_d;
      ecc_irq_q <= fail_d;
      lcrc_q    <= lcrc_d;
      boot_q    <= boot_d;
      st_q      <= st_d;
      en_q      <= en_d;
      pause_q   <= busy_d ? pause_d : 1'b0;
      p1_q      <= p1_d;
      p2_q      <= p1_q;
      rsp_q     <= rsp_d;
    end
  end

  //------------------------------------------------------------
  // array crc engine and array port
  //------------------------------------------------------------
  // one word per three cycles; host reads take the port first
  always_comb begin
    cur_d  = cur_q;
    acrc_d = acrc_q;
    busy_d = acrc_busy_q;
    issue  = acrc_busy_q && !pause_q && !host_arr && (ep_q == 2'b00);
    ep_d   = {ep_q[0], issue};
    if (ep_q[1]) begin
      acrc_d = crc_step(acrc_q, arr_rdata);
      cur_d  = cur_q + 32'h00000001;
      if (cur_q == en_q) busy_d = 1'b0;
    end
    if (cmd.vld && in_acrc && cmd.op == orx_pkg::op_load_crc_end) begin
      cur_d  = st_q;
      acrc_d = `ORX_CRC_INIT;
      busy_d = 1'b1;
      ep_d   = 2'b00;
    end
    arr_req_d  = host_arr || issue;
    arr_addr_d = host_arr ? host_addr : cur_q;
  end

  // register engine and port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_q       <= '0;
      acrc_q      <= `ORX_CRC_INIT;
      acrc_busy_q <= 1'b0;
      ep_q        <= 2'b00;
      arr_req_q   <= 1'b0;
      arr_addr_q  <= '0;
    end else begin
      cur_q       <= cur_d;
      acrc_q      <= acrc_d;
      acrc_busy_q <= busy_d;
      ep_q        <= ep_d;
      arr_req_q   <= arr_req_d;
      arr_addr_q  <= arr_addr_d;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_ecc_entry;
    cmd.vld && cmd.op == orx_pkg::op_ecc_overlay_entry |=> ovl_q == orx_pkg::ovl_ecc;
  endproperty
  a_ecc_entry: assert property (p_ecc_entry) else $error("ecc entry missed");

  property p_hp_addr;
    cmd.vld && cmd.op == orx_pkg::op_read_ecc_status && in_ecc
      |=> arr_req_q && arr_addr_q[`ORX_HP_LSB-1:0] == '0 ##2 rsp_q.vld && rsp_q.data == $past(ecc_hp_status);
  endproperty
  a_hp_addr: assert property (p_hp_addr) else $error("half-page status wrong");

  property p_trap_lo;
    cmd.vld && cmd.op == orx_pkg::op_read_trap_low && in_ecc |-> ##3 rsp_q.data == $past(trap_q[15:0]);
  endproperty
  a_trap_lo: assert property (p_trap_lo) else $error("trap low wrong");

  property p_trap_hi;
    cmd.vld && cmd.op == orx_pkg::op_read_trap_high && in_ecc |-> ##3 rsp_q.data == $past(trap_q[31:16]);
  endproperty
  a_trap_hi: assert property (p_trap_hi) else $error("trap high wrong");

  property p_cnt;
    cmd.vld && cmd.op == orx_pkg::op_read_correction_count && in_ecc
      |-> ##3 rsp_q.vld && rsp_q.data == 16'($past(cnt_q));
  endproperty
  a_cnt: assert property (p_cnt) else $error("count wrong");

  property p_clr;
    cmd.vld && cmd.op == orx_pkg::op_clear_ecc_flags && in_ecc && !ecc_evt |=> !ecc_irq_q;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");

  property p_exit;
    cmd.vld && cmd.op == orx_pkg::op_overlay_exit |=> ovl_q == orx_pkg::ovl_none;
  endproperty
  a_exit: assert property (p_exit) else $error("exit missed");

  property p_lcrc_clr;
    in_link && cmd.vld && cmd.op == orx_pkg::op_overlay_exit |=> lcrc_q == `ORX_LCRC_CLR;
  endproperty
  a_lcrc_clr: assert property (p_lcrc_clr) else $error("link crc kept");

  property p_paused_rd;
    cmd.vld && cmd.op == orx_pkg::op_read_array_while_paused && in_acrc && pause_q
      |=> arr_req_q && arr_addr_q == $past(cmd.addr);
  endproperty
  a_paused_rd: assert property (p_paused_rd) else $error("paused read lost");

  property p_boot_keep;
    cmd.vld && cmd.op == orx_pkg::op_program_boot_cfg && !in_boot |=> $stable(boot_q);
  endproperty
  a_boot_keep: assert property (p_boot_keep) else $error("boot written outside overlay");

  c_acrc_done: cover property (acrc_busy_q ##1 !acrc_busy_q);
  c_pause: cover property (pause_q && arr_req_q);
  c_boot_pgm: cover property (in_boot && cmd.vld && cmd.op == orx_pkg::op_program_boot_cfg);

endmodule
`default_nettype wire

//--- sim/orx_array_model.sv
// memory array model facing the overlay block's array port
// assumes requests are sampled on the rising edge of the block's clock
`timescale 1ns/10ps
`default_nettype none

module orx_array_model (
  // clock
  input  wire logic        clk,
  // request from the block
  input  wire logic        arr_req_q,
  input  wire logic [31:0] arr_addr_q,
  // answer, valid the cycle after a request
  output logic [15:0]      arr_rdata,
  output logic [15:0]      ecc_hp_status
);
  // -----------------------------------------------------------------
  // answer path
  // -----------------------------------------------------------------
  initial begin
    arr_rdata     = 16'h0000;
    ecc_hp_status = 16'h0000;
  end

  // data follows the address; idle cycles toggle so stale data matches again only after an even number of them
  always @(posedge clk) begin
    if (arr_req_q) begin
      arr_rdata     <= arr_addr_q[15:0] ^ 16'h5a3c;
      ecc_hp_status <= arr_addr_q[15:0] ^ 16'hc3a5;
    end else begin
      arr_rdata     <= ~arr_rdata;
      ecc_hp_status <= ~ecc_hp_status;
    end
  end
endmodule

`default_nettype wire

//--- sim/overlay_region_transactions_tb.sv
// self-checking bench for the overlay command interpreter
// assumes orx_core and the array model; inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
`include "orx_consts.svh"

module overlay_region_transactions_tb;
  // -----------------------------------------------------------------
  // signals and instances
  // -----------------------------------------------------------------
  logic              clk = 1'b0;
  logic              rst_n, ecc_evt, ecc_evt_fail, lcrc_upd;
  logic              arr_req_q, ecc_irq_q, acrc_busy_q;
  logic [31:0]       ecc_evt_addr, lcrc_val, arr_addr_q;
  logic [15:0]       arr_rdata, ecc_hp_status;
  orx_pkg::orx_cmd_t cmd;
  orx_pkg::orx_rsp_t rsp_q;
  orx_pkg::orx_ovl_t ovl_q;
  int                errors = 0;
  int                n_compared = 0;
  int                cyc = 0;

  orx_core #(.CNT_W(16)) u_dut (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp_q(rsp_q),
    .arr_req_q(arr_req_q), .arr_addr_q(arr_addr_q), .arr_rdata(arr_rdata),
    .ecc_hp_status(ecc_hp_status), .ecc_evt(ecc_evt), .ecc_evt_addr(ecc_evt_addr),
    .ecc_evt_fail(ecc_evt_fail), .ecc_irq_q(ecc_irq_q), .lcrc_upd(lcrc_upd),
    .lcrc_val(lcrc_val), .ovl_q(ovl_q), .acrc_busy_q(acrc_busy_q)
  );

  orx_array_model u_arr (
    .clk(clk), .arr_req_q(arr_req_q), .arr_addr_q(arr_addr_q),
    .arr_rdata(arr_rdata), .ecc_hp_status(ecc_hp_status)
  );

  // clock and a cycle ceiling against hangs
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      finish_test();
    end
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [15:0] mem(input logic [31:0] a);
    return a[15:0] ^ 16'h5a3c;
  endfunction

  // crc over model words, msb first, word bit 15 first
  function automatic logic [31:0] crc(input logic [31:0] s, input logic [31:0] e);
    logic [31:0] c;
    logic [15:0] w;
    c = `ORX_CRC_INIT;
    for (logic [31:0] a = s; a <= e; a++) begin
      w = mem(a);
      for (int i = 15; i >= 0; i--) begin
        c = (c[31] ^ w[i]) ? ({c[30:0], 1'b0} ^ `ORX_CRC_POLY) : {c[30:0], 1'b0};
      end
    end
    return c;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic co(input orx_pkg::orx_ovl_t e);
    chk("overlay", {29'h0, e}, {29'h0, ovl_q});
  endtask

  // one-cycle command pulse
  task automatic go(input orx_pkg::orx_op_t op, input logic [31:0] a, input logic [15:0] w);
    @(negedge clk);
    cmd = '{vld: 1'b1, op: op, addr: a, wdata: w};
    @(negedge clk);
    cmd.vld = 1'b0;
  endtask

  // read with reply two cycles after the taking edge; go returns one cycle in
  task automatic rd(input string n, input orx_pkg::orx_op_t op, input logic [31:0] a, input logic [15:0] e);
    go(op, a, 16'h0000);
    repeat (2) @(negedge clk);
    chk({n, " valid"}, 32'h1, {31'h0, rsp_q.vld});
    chk(n, {16'h0, e}, {16'h0, rsp_q.data});
  endtask

  task automatic evt(input logic [31:0] a, input logic f);
    @(negedge clk);
    ecc_evt      = 1'b1;
    ecc_evt_addr = a;
    ecc_evt_fail = f;
    @(negedge clk);
    ecc_evt      = 1'b0;
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_ecc;
    evt(32'h0001_2345, 1'b1);
    evt(32'h00ab_cdef, 1'b0);
    @(negedge clk);
    go(orx_pkg::op_clear_ecc_flags, 32'h0, 16'h0);
    chk("irq kept", 32'h1, {31'h0, ecc_irq_q});
    go(orx_pkg::op_ecc_overlay_entry, 32'h0, 16'h0);
    co(orx_pkg::ovl_ecc);
    rd("trap low", orx_pkg::op_read_trap_low, 32'h0, 16'hcdef);
    rd("trap high", orx_pkg::op_read_trap_high, 32'h0, 16'h00ab);
    rd("count", orx_pkg::op_read_correction_count, 32'h0, 16'h0002);
    rd("status a", orx_pkg::op_read_ecc_status, 32'h25, 16'h0020 ^ 16'hc3a5);
    rd("status b", orx_pkg::op_read_ecc_status, 32'h22, 16'h0020 ^ 16'hc3a5);
    go(orx_pkg::op_clear_ecc_flags, 32'h0, 16'h0);
    rd("count cleared", orx_pkg::op_read_correction_count, 32'h0, 16'h0000);
    chk("irq cleared", 32'h0, {31'h0, ecc_irq_q});
    // clear and a failing event in one cycle: the event wins
    @(negedge clk);
    cmd          = '{vld: 1'b1, op: orx_pkg::op_clear_ecc_flags, addr: 32'h0, wdata: 16'h0};
    ecc_evt      = 1'b1;
    ecc_evt_addr = 32'h0000_0077;
    ecc_evt_fail = 1'b1;
    @(negedge clk);
    cmd.vld      = 1'b0;
    ecc_evt      = 1'b0;
    chk("irq set wins", 32'h1, {31'h0, ecc_irq_q});
    rd("count set wins", orx_pkg::op_read_correction_count, 32'h0, 16'h0001);
    go(orx_pkg::op_overlay_exit, 32'h0, 16'h0);
    co(orx_pkg::ovl_none);
    rd("array", orx_pkg::op_read_array, 32'h33, mem(32'h33));
  endtask

  task automatic t_link;
    @(negedge clk);
    lcrc_upd = 1'b1;
    lcrc_val = 32'h1234_abcd;
    @(negedge clk);
    lcrc_upd = 1'b0;
    go(orx_pkg::op_link_crc_overlay_entry, 32'h0, 16'h0);
    rd("link low", orx_pkg::op_read_link_crc, 32'h0, 16'habcd);
    rd("link high", orx_pkg::op_read_link_crc, 32'h1, 16'h1234);
    go(orx_pkg::op_overlay_exit, 32'h0, 16'h0);
    go(orx_pkg::op_link_crc_overlay_entry, 32'h0, 16'h0);
    rd("link cleared", orx_pkg::op_read_link_crc, 32'h1, 16'h0000);
    go(orx_pkg::op_overlay_exit, 32'h0, 16'h0);
  endtask

  task automatic t_boot;
    go(orx_pkg::op_program_boot_cfg, 32'h0, 16'hffff);
    go(orx_pkg::op_boot_cfg_overlay_entry, 32'h0004_0000, 16'h0);
    co(orx_pkg::ovl_boot);
    rd("boot untouched", orx_pkg::op_read_boot_cfg, 32'h0, 16'h0000);
    go(orx_pkg::op_program_boot_cfg, 32'h0, 16'h5a01);
    go(orx_pkg::op_program_boot_cfg, 32'h1, 16'h00c3);
    rd("boot low", orx_pkg::op_read_boot_cfg, 32'h0, 16'h5a01);
    rd("boot high", orx_pkg::op_read_boot_cfg, 32'h1, 16'h00c3);
    go(orx_pkg::op_overlay_exit, 32'h0, 16'h0);
  endtask

  task automatic t_crc;
    logic [31:0] x;
    int          k;
    x = crc(32'h100, 32'h10f);
    go(orx_pkg::op_array_crc_overlay_entry, 32'h0, 16'h0);
    co(orx_pkg::ovl_acrc);
    go(orx_pkg::op_load_crc_start, 32'h100, 16'h0);
    go(orx_pkg::op_load_crc_end, 32'h10f, 16'h0);
    repeat (6) @(negedge clk);
    go(orx_pkg::op_pause_array_crc, 32'h0, 16'h0);
    repeat (20) @(negedge clk);
    chk("busy paused", 32'h1, {31'h0, acrc_busy_q});
    rd("paused read", orx_pkg::op_read_array_while_paused, 32'h40, mem(32'h40));
    rd("paused array", orx_pkg::op_read_array, 32'h41, mem(32'h41));
    go(orx_pkg::op_continue_array_crc, 32'h0, 16'h0);
    k = 0;
    while (acrc_busy_q === 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk("busy done", 32'h0, {31'h0, acrc_busy_q});
    rd("crc low", orx_pkg::op_read_array_crc_low, 32'h0, x[15:0]);
    rd("crc high", orx_pkg::op_read_array_crc_high, 32'h0, x[31:16]);
    rd("overlay word", orx_pkg::op_read_array, 32'h1, x[31:16]);
    go(orx_pkg::op_overlay_exit, 32'h0, 16'h0);
  endtask

  // -----------------------------------------------------------------
  // main sequence and verdict
  // -----------------------------------------------------------------
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst_n        = 1'b0;
    cmd          = '0;
    ecc_evt      = 1'b0;
    ecc_evt_addr = 32'h0;
    ecc_evt_fail = 1'b0;
    lcrc_upd     = 1'b0;
    lcrc_val     = 32'h0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    co(orx_pkg::ovl_none);
    chk("busy reset", 32'h0, {31'h0, acrc_busy_q});
    t_ecc();
    t_link();
    t_boot();
    t_crc();
    finish_test();
  end
endmodule

`default_nettype wire
